// [pkg/ilc_eval_if.sv]
/*
 * Carries one classification request and its answer between the
 * register/sample core and the level state machine. Combinational only.
 */
interface ilc_eval_if;
    logic [15:0]         value;
    logic [15:0]         hthr;
    logic [15:0]         hhys;
    logic [15:0]         lthr;
    logic [15:0]         lhys;
    logic                first;
    ilc_pkg::ilc_state_t cur;
    ilc_pkg::ilc_state_t nxt;

    modport req (output value, hthr, hhys, lthr, lhys, first, cur, input nxt);
    modport cls (input value, hthr, hhys, lthr, lhys, first, cur, output nxt);
endinterface

// [pkg/ilc_pkg.sv]
/*
 * Shared constants, types and arithmetic for the input level classifier.
 * Assumes a single 10 MHz clock domain and a plain register port.
 */
package ilc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH    = 11;
    localparam int NUM_VOLT  = 8;
    localparam int CH_W      = 4;
    localparam int VAL_W     = 16;
    localparam int ADC_W     = 12;
    localparam int ADR_W     = 8;
    localparam int EVAL_LAT  = 2;

    // ------------------------------------------------------------------
    // Register map: address = {channel, field}; channel 0xf holds globals
    // ------------------------------------------------------------------
    localparam logic [3:0] F_HTHR    = 4'h0;
    localparam logic [3:0] F_HHYS    = 4'h1;
    localparam logic [3:0] F_LTHR    = 4'h2;
    localparam logic [3:0] F_LHYS    = 4'h3;
    localparam logic [3:0] F_CFG     = 4'h4;
    localparam logic [3:0] F_MEAS    = 4'h5;
    localparam logic [3:0] F_STATE   = 4'h6;
    localparam logic [3:0] G_CH      = 4'hf;
    localparam logic [3:0] G_REPORT  = 4'h0;
    localparam logic [3:0] G_ISTAT   = 4'h1;
    localparam logic [3:0] G_IMASK   = 4'h2;

    // Configuration word fields.
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_REF_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_HTHR  = 16'hffff;
    localparam logic [15:0] RST_LTHR  = 16'h0000;
    localparam logic [15:0] RST_HYS   = 16'h0000;
    localparam logic [1:0]  RST_CFG   = 2'h0;
    localparam logic [15:0] REF5_MV   = 16'h1388;

    typedef enum logic [1:0] {ILC_LOW, ILC_MID, ILC_HIGH} ilc_state_t;

    // Saturating add and subtract keep hysteresis bands inside the scale.
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16] ? 16'hffff : s[15:0];
    endfunction

    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? (a - b) : 16'h0000;
    endfunction

    // Scales a converter code to millivolts over a reference span.
    function automatic logic [15:0] scale_mv(input logic [11:0] raw, input logic [15:0] ref_mv);
        logic [27:0] p;
        p = 28'(raw) * 28'(ref_mv);
        return p[27:12];
    endfunction

endpackage

// [rtl/ilc_level_fsm.sv]
/*
 * Next-state logic for one channel's three-level state with hysteresis.
 * Combinational; the caller holds the state per channel.
 */
module ilc_level_fsm
(
    ilc_eval_if.cls bus
);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Rising moves use the bare thresholds; falling moves use the bands.
    always_comb
    begin
        logic [15:0] hi_fall;
        logic [15:0] lo_fall;
        hi_fall = ilc_pkg::sat_sub(bus.hthr, bus.hhys);
        lo_fall = ilc_pkg::sat_add(bus.lthr, bus.lhys);
        bus.nxt = bus.cur;
        if (bus.first)
        begin
            // No history yet, so no hysteresis is applied.
            if (bus.value > bus.hthr)
                bus.nxt = ilc_pkg::ILC_HIGH; // RULE10
            else if (bus.value < bus.lthr)
                bus.nxt = ilc_pkg::ILC_LOW;
            else
                bus.nxt = ilc_pkg::ILC_MID;
        end
        else
        begin
            case (bus.cur)
                ilc_pkg::ILC_LOW:
                begin
                    if (bus.value > bus.hthr)
                        bus.nxt = ilc_pkg::ILC_HIGH;
                    else if (bus.value > bus.lthr)
                        bus.nxt = ilc_pkg::ILC_MID; // RULE7
                end
                ilc_pkg::ILC_MID:
                begin
                    if (bus.value > bus.hthr)
                        bus.nxt = ilc_pkg::ILC_HIGH; // RULE7
                    else if (bus.value < lo_fall)
                        bus.nxt = ilc_pkg::ILC_LOW; // RULE9
                end
                default:
                begin
                    if (bus.value < hi_fall)
                        bus.nxt = (bus.value < lo_fall) ? ilc_pkg::ILC_LOW
                                                        : ilc_pkg::ILC_MID; // RULE8
                end
            endcase
        end
    end

endmodule

// [rtl/ilc_ref_scaler.sv]
/*
 * Turns a raw sample into a measured value. Voltage channels scale a
 * converter code over the selected reference; other channels pass through.
 * Assumes the supply measurement is already in millivolts.
 */
module ilc_ref_scaler
(
    input  wire logic [15:0] i_raw,
    input  wire logic        i_is_volt,
    input  wire logic        i_ref_supply,
    input  wire logic [15:0] i_supply_mv,
    output logic      [15:0] o_value
);

    // ------------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------------
    // The fixed reference gives finer steps; the supply reference trades
    // resolution for a span up to the supply rail.
    always_comb
    begin
        if (!i_is_volt)
            o_value = i_raw;
        else if (i_ref_supply)
            o_value = ilc_pkg::scale_mv(i_raw[11:0], i_supply_mv); // RULE4
        else
            o_value = ilc_pkg::scale_mv(i_raw[11:0], ilc_pkg::REF5_MV); // RULE3
    end

endmodule

// [rtl/ilc_top.sv]
/*
 * Input level classifier: eleven measured channels, each with high and low
 * thresholds and hysteresis, a three-level state, a binary report bit with
 * selectable polarity, and a per-channel interrupt on state change after the channel's first sample.
 * Assumes samples arrive one per cycle at most on a synchronous strobe and
 * that software reaches the registers over a one-cycle plain port.
 */
// Decided for this implementation: strobed register access and the register offsets.

// What this block does
// RULE1: Low polarity: report ON below low threshold.
// RULE2: High polarity: report ON above high threshold.
// RULE3: Fixed reference scales input over zero to five volts.
// RULE4: Supply reference scales input up to supply.
// RULE5: Readable per-channel state: low, middle or high.
// RULE6: Readable present measurement per channel.
// RULE7: Rising past thresholds moves low-mid-high.
// RULE8: High falls to middle below threshold minus hysteresis.
// RULE9: Middle falls low below low threshold plus hysteresis.
// RULE10: First sample classifies without hysteresis.
module ilc_top
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_smp_valid,
    input  wire logic [3:0]  i_smp_chan,
    input  wire logic [15:0] i_smp_raw,
    input  wire logic [15:0] i_supply_mv,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_irq,
    output logic      [10:0] o_report
);

    localparam int N = ilc_pkg::NUM_CH;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0]         hthr_r  [N];
    logic [15:0]         hhys_r  [N];
    logic [15:0]         lthr_r  [N];
    logic [15:0]         lhys_r  [N];
    logic [1:0]          cfg_r   [N];
    logic [15:0]         meas_r  [N];
    ilc_pkg::ilc_state_t state_r [N];
    logic [N-1:0]        seen_r;
    logic [N-1:0]        istat_r;
    logic [N-1:0]        imask_r;
    logic [N-1:0]        istat_nxt;
    logic [N-1:0]        evt_nxt;
    logic                s1_vld_r;
    logic [3:0]          s1_ch_r;
    logic [15:0]         s1_val_r;
    logic [15:0]         scaled;
    logic                smp_ok;
    logic                s1_pol;
    logic [3:0]          wr_ch;
    logic [3:0]          wr_fld;
    logic                wr_chan_ok;
    logic                report_bit;

    ilc_eval_if u_eval ();

    assign smp_ok     = i_smp_valid && (i_smp_chan < 4'(N));
    assign wr_ch      = i_addr[7:4];
    assign wr_fld     = i_addr[3:0];
    assign wr_chan_ok = i_wr && (wr_ch < 4'(N));

    // ------------------------------------------------------------------
    // Sample path, stage 1: scale over the channel's reference
    // ------------------------------------------------------------------
    ilc_ref_scaler u_scaler
    (
        .i_raw        (i_smp_raw),
        .i_is_volt    (i_smp_chan < 4'(ilc_pkg::NUM_VOLT)),
        .i_ref_supply (smp_ok ? cfg_r[i_smp_chan][ilc_pkg::CFG_REF_BIT] : 1'b0),
        .i_supply_mv  (i_supply_mv),
        .o_value      (scaled)
    );

    // Out-of-range channel numbers are dropped here so no array is
    // indexed past its end further down.
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s1_vld_r <= 1'b0;
            s1_ch_r  <= 4'h0;
            s1_val_r <= 16'h0000;
        end
        else
        begin
            s1_vld_r <= smp_ok;
            if (smp_ok)
            begin
                s1_ch_r  <= i_smp_chan;
                s1_val_r <= scaled; // RULE3 RULE4
            end
        end
    end

    // ------------------------------------------------------------------
    // Sample path, stage 2: classification
    // ------------------------------------------------------------------
    assign u_eval.value = s1_val_r;
    assign u_eval.hthr  = hthr_r[s1_ch_r];
    assign u_eval.hhys  = hhys_r[s1_ch_r];
    assign u_eval.lthr  = lthr_r[s1_ch_r];
    assign u_eval.lhys  = lhys_r[s1_ch_r];
    assign u_eval.first = !seen_r[s1_ch_r];
    assign u_eval.cur   = state_r[s1_ch_r];

    ilc_level_fsm u_fsm
    (
        .bus (u_eval.cls)
    );

    // Report bit follows the measurement and polarity, not the state, so
    // hysteresis does not delay it.
    assign s1_pol = cfg_r[s1_ch_r][ilc_pkg::CFG_POL_BIT];
    always_comb
    begin
        if (s1_pol)
            report_bit = s1_val_r > hthr_r[s1_ch_r]; // RULE2
        else
            report_bit = s1_val_r < lthr_r[s1_ch_r]; // RULE1
    end

    // State and measurement per channel, written on each new sample.
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < N; i++)
            begin
                state_r[i] <= ilc_pkg::ILC_LOW;
                meas_r[i]  <= 16'h0000;
            end
            seen_r <= '0;
        end
        else if (s1_vld_r)
        begin
            state_r[s1_ch_r] <= u_eval.nxt; // RULE5 RULE7 RULE8 RULE9 RULE10
            meas_r[s1_ch_r]  <= s1_val_r; // RULE6
            seen_r[s1_ch_r]  <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_report <= '0;
        else if (s1_vld_r)
            o_report[s1_ch_r] <= report_bit; // RULE1 RULE2
    end

    // ------------------------------------------------------------------
    // Interrupts: a state change after the channel's first sample is an event; set wins over clear
    // ------------------------------------------------------------------
    always_comb
    begin
        evt_nxt = '0;
        if (s1_vld_r && seen_r[s1_ch_r] && (u_eval.nxt != state_r[s1_ch_r]))
            evt_nxt[s1_ch_r] = 1'b1;
        istat_nxt = istat_r;
        if (i_wr && (wr_ch == ilc_pkg::G_CH) && (wr_fld == ilc_pkg::G_ISTAT))
            istat_nxt = istat_r & ~i_wdata[N-1:0];
        istat_nxt = istat_nxt | evt_nxt;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            istat_r <= '0;
            imask_r <= '0;
        end
        else
        begin
            istat_r <= istat_nxt;
            if (i_wr && (wr_ch == ilc_pkg::G_CH) && (wr_fld == ilc_pkg::G_IMASK))
                imask_r <= i_wdata[N-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_irq <= 1'b0;
        else
            o_irq <= |(istat_nxt & imask_r);
    end

    // ------------------------------------------------------------------
    // Channel configuration writes
    // ------------------------------------------------------------------
    // Measurement and state are read-only; writes to them are ignored.
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < N; i++)
            begin
                hthr_r[i] <= ilc_pkg::RST_HTHR;
                hhys_r[i] <= ilc_pkg::RST_HYS;
                lthr_r[i] <= ilc_pkg::RST_LTHR;
                lhys_r[i] <= ilc_pkg::RST_HYS;
                cfg_r[i]  <= ilc_pkg::RST_CFG;
            end
        end
        else if (wr_chan_ok)
        begin
            if (wr_fld == ilc_pkg::F_HTHR)
                hthr_r[wr_ch] <= i_wdata;
            else if (wr_fld == ilc_pkg::F_HHYS)
                hhys_r[wr_ch] <= i_wdata;
            else if (wr_fld == ilc_pkg::F_LTHR)
                lthr_r[wr_ch] <= i_wdata;
            else if (wr_fld == ilc_pkg::F_LHYS)
                lhys_r[wr_ch] <= i_wdata;
            else if (wr_fld == ilc_pkg::F_CFG)
                cfg_r[wr_ch] <= i_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read port: data stand in the cycle after the strobe only
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= 16'h0000;
        else if (!i_rd)
            o_rdata <= 16'h0000;
        else if (wr_ch == ilc_pkg::G_CH)
        begin
            if (wr_fld == ilc_pkg::G_REPORT)
                o_rdata <= {5'h00, o_report};
            else if (wr_fld == ilc_pkg::G_ISTAT)
                o_rdata <= {5'h00, istat_r};
            else if (wr_fld == ilc_pkg::G_IMASK)
                o_rdata <= {5'h00, imask_r};
            else
                o_rdata <= 16'h0000;
        end
        else if (wr_ch < 4'(N))
        begin
            if (wr_fld == ilc_pkg::F_HTHR)
                o_rdata <= hthr_r[wr_ch];
            else if (wr_fld == ilc_pkg::F_HHYS)
                o_rdata <= hhys_r[wr_ch];
            else if (wr_fld == ilc_pkg::F_LTHR)
                o_rdata <= lthr_r[wr_ch];
            else if (wr_fld == ilc_pkg::F_LHYS)
                o_rdata <= lhys_r[wr_ch];
            else if (wr_fld == ilc_pkg::F_CFG)
                o_rdata <= {14'h0000, cfg_r[wr_ch]};
            else if (wr_fld == ilc_pkg::F_MEAS)
                o_rdata <= meas_r[wr_ch]; // RULE6
            else if (wr_fld == ilc_pkg::F_STATE)
                o_rdata <= {14'h0000, state_r[wr_ch]}; // RULE5
            else
                o_rdata <= 16'h0000;
        end
        else
            o_rdata <= 16'h0000;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_report_low;
        s1_vld_r && !s1_pol && (s1_val_r < lthr_r[s1_ch_r])
            |=> o_report[$past(s1_ch_r)];
    endproperty
    a_report_low: assert property (p_report_low) else $error("low polarity report not ON"); // RULE1

    property p_report_high;
        s1_vld_r && s1_pol && (s1_val_r > hthr_r[s1_ch_r])
            |=> o_report[$past(s1_ch_r)];
    endproperty
    a_report_high: assert property (p_report_high) else $error("high polarity report not ON"); // RULE2

    property p_ref_fixed;
        smp_ok && (i_smp_chan < 4'(ilc_pkg::NUM_VOLT)) && !cfg_r[i_smp_chan][1]
            |=> s1_val_r == ilc_pkg::scale_mv($past(i_smp_raw[11:0]), ilc_pkg::REF5_MV);
    endproperty
    a_ref_fixed: assert property (p_ref_fixed) else $error("fixed reference scaling wrong"); // RULE3

    property p_ref_supply;
        smp_ok && (i_smp_chan < 4'(ilc_pkg::NUM_VOLT)) && cfg_r[i_smp_chan][1]
            |=> s1_val_r == ilc_pkg::scale_mv($past(i_smp_raw[11:0]), $past(i_supply_mv));
    endproperty
    a_ref_supply: assert property (p_ref_supply) else $error("supply reference scaling wrong"); // RULE4

    property p_state_read;
        i_rd && (wr_ch < 4'(N)) && (wr_fld == ilc_pkg::F_STATE) && !s1_vld_r
            |=> (o_rdata[1:0] == state_r[$past(wr_ch)]) && (o_rdata[15:2] == 14'h0000);
    endproperty
    a_state_read: assert property (p_state_read) else $error("state readback wrong"); // RULE5

    property p_meas_update;
        s1_vld_r |=> meas_r[$past(s1_ch_r)] == $past(s1_val_r);
    endproperty
    a_meas_update: assert property (p_meas_update) else $error("measurement not stored"); // RULE6

    property p_rise_mid;
        s1_vld_r && seen_r[s1_ch_r] && (state_r[s1_ch_r] == ilc_pkg::ILC_LOW)
            && (s1_val_r > lthr_r[s1_ch_r]) && (s1_val_r <= hthr_r[s1_ch_r])
            |=> state_r[$past(s1_ch_r)] == ilc_pkg::ILC_MID;
    endproperty
    a_rise_mid: assert property (p_rise_mid) else $error("low to mid not taken"); // RULE7

    property p_high_hold;
        s1_vld_r && seen_r[s1_ch_r] && (state_r[s1_ch_r] == ilc_pkg::ILC_HIGH)
            && (s1_val_r >= ilc_pkg::sat_sub(hthr_r[s1_ch_r], hhys_r[s1_ch_r]))
            |=> state_r[$past(s1_ch_r)] == ilc_pkg::ILC_HIGH;
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("high left inside band"); // RULE8

    property p_fall_low;
        s1_vld_r && seen_r[s1_ch_r] && (state_r[s1_ch_r] == ilc_pkg::ILC_MID)
            && (s1_val_r <= hthr_r[s1_ch_r])
            && (s1_val_r < ilc_pkg::sat_add(lthr_r[s1_ch_r], lhys_r[s1_ch_r]))
            |=> state_r[$past(s1_ch_r)] == ilc_pkg::ILC_LOW;
    endproperty
    a_fall_low: assert property (p_fall_low) else $error("mid to low not taken"); // RULE9

    property p_first_high;
        s1_vld_r && !seen_r[s1_ch_r] && (s1_val_r > hthr_r[s1_ch_r])
            |=> state_r[$past(s1_ch_r)] == ilc_pkg::ILC_HIGH;
    endproperty
    a_first_high: assert property (p_first_high) else $error("first sample not classified"); // RULE10

    c_to_high: cover property (s1_vld_r && (u_eval.nxt == ilc_pkg::ILC_HIGH) && seen_r[s1_ch_r]);
    c_irq:     cover property (!o_irq ##1 o_irq);
    c_clr_set: cover property (|(evt_nxt & istat_r) && i_wr && (wr_fld == ilc_pkg::G_ISTAT));

endmodule

// [verification/ilc_sensor_model.sv]
/*
 * Behavioural model of the sensor front end that hands samples to the
 * classifier. Assumes the bench raises i_go for one cycle per sample,
 * changing it just after a rising edge.
 */
module ilc_sensor_model
(
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [3:0]  i_chan,
    input  wire logic [15:0] i_raw,
    output logic             o_smp_valid,
    output logic      [3:0]  o_smp_chan,
    output logic      [15:0] o_smp_raw
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] last_r = 16'h0000;

    // Remember the last value sent so the idle bus can show its inverse.
    always @(posedge i_clk)
    begin
        if (i_go)
            last_r <= i_raw;
    end

    // Outside a sample the lines carry garbage, so stale data is never trusted.
    assign o_smp_valid = i_go;
    assign o_smp_chan  = i_go ? i_chan : ~i_chan;
    assign o_smp_raw   = i_go ? i_raw : ~last_r;
endmodule

// [verification/ilc_top_tb.sv]
/*
 * Self-checking bench for the input level classifier top.
 * Assumes a 10 MHz clock and the sensor model as the sample source.
 */
module ilc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0]  ch;
        logic [1:0]  cfg;
        logic [15:0] raw;
        logic [15:0] meas;
        logic [1:0]  st;
        logic        rep;
    } ilc_row_t;

    // --------------------------------------------------------------
    // Sample sequence: hysteresis walk on the current channel, then scaling
    // --------------------------------------------------------------
    localparam ilc_row_t ROWS [12] = '{
        '{4'ha, 2'h1, 16'h0032, 16'h0032, 2'h1, 1'b0},
        '{4'ha, 2'h1, 16'h006e, 16'h006e, 2'h2, 1'b1},
        '{4'ha, 2'h1, 16'h005a, 16'h005a, 2'h2, 1'b0},
        '{4'ha, 2'h1, 16'h004f, 16'h004f, 2'h1, 1'b0},
        '{4'ha, 2'h1, 16'h003c, 16'h003c, 2'h1, 1'b0},
        '{4'ha, 2'h1, 16'h0031, 16'h0031, 2'h0, 1'b0},
        '{4'ha, 2'h1, 16'h0029, 16'h0029, 2'h1, 1'b0},
        '{4'ha, 2'h1, 16'h0078, 16'h0078, 2'h2, 1'b1},
        '{4'ha, 2'h1, 16'h000a, 16'h000a, 2'h0, 1'b0},
        '{4'h0, 2'h0, 16'h0800, 16'h09c4, 2'h1, 1'b0},
        '{4'h0, 2'h2, 16'hf800, 16'h1770, 2'h1, 1'b0},
        '{4'h1, 2'h0, 16'h0100, 16'h0138, 2'h0, 1'b1}
    };

    logic        i_sys_clk   = 1'b0;
    logic        i_rst_b     = 1'b0;
    logic        go          = 1'b0;
    logic [3:0]  go_chan     = 4'h0;
    logic [15:0] go_raw      = 16'h0000;
    logic        i_smp_valid;
    logic [3:0]  i_smp_chan;
    logic [15:0] i_smp_raw;
    logic [15:0] i_supply_mv = 16'h2ee0;
    logic [7:0]  i_addr      = 8'h00;
    logic [15:0] i_wdata     = 16'h0000;
    logic        i_wr        = 1'b0;
    logic        i_rd        = 1'b0;
    logic [15:0] o_rdata;
    logic        o_irq;
    logic [10:0] o_report;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    // Free-running 100 ns clock.
    always #50 i_sys_clk = ~i_sys_clk;

    ilc_sensor_model SRC (.i_clk(i_sys_clk), .i_go(go), .i_chan(go_chan), .i_raw(go_raw),
        .o_smp_valid(i_smp_valid), .o_smp_chan(i_smp_chan), .o_smp_raw(i_smp_raw));

    ilc_top DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_smp_valid(i_smp_valid),
        .i_smp_chan(i_smp_chan), .i_smp_raw(i_smp_raw), .i_supply_mv(i_supply_mv),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_report(o_report));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, then drop to zero.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1 chk_data(o_rdata, exp);
        @(posedge i_sys_clk);
        #1 chk_data(o_rdata, 16'h0000);
    endtask

    // One sample, then wait out the two-edge latency before looking.
    task automatic smp(input logic [3:0] c, input logic [15:0] r);
        @(posedge i_sys_clk);
        go      <= 1'b1;
        go_chan <= c;
        go_raw  <= r;
        @(posedge i_sys_clk);
        go      <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles.
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        chk_data({5'h00, o_report}, 16'h0000);
        chk_bit(o_irq, 1'b0);
        rd({4'h3, ilc_pkg::F_HTHR}, 16'hffff);
        rd({4'h3, ilc_pkg::F_LTHR}, 16'h0000);
        rd({4'h3, ilc_pkg::F_CFG}, 16'h0000);
        rd({4'h3, ilc_pkg::F_STATE}, 16'h0000);
        wr({4'ha, ilc_pkg::F_HTHR}, 16'h0064);
        wr({4'ha, ilc_pkg::F_HHYS}, 16'h0014);
        wr({4'ha, ilc_pkg::F_LTHR}, 16'h0028);
        wr({4'ha, ilc_pkg::F_LHYS}, 16'h000a);
        wr({4'h1, ilc_pkg::F_LTHR}, 16'h03e8);
        foreach (ROWS[i])
        begin
            wr({ROWS[i].ch, ilc_pkg::F_CFG}, {14'h0000, ROWS[i].cfg});
            smp(ROWS[i].ch, ROWS[i].raw);
            chk_bit(o_report[ROWS[i].ch], ROWS[i].rep);
            rd({ROWS[i].ch, ilc_pkg::F_MEAS}, ROWS[i].meas);
            rd({ROWS[i].ch, ilc_pkg::F_STATE}, {14'h0000, ROWS[i].st});
        end
        // Only the current channel changed state after its first sample.
        rd(8'hf1, 16'h0400);
        chk_bit(o_irq, 1'b0);
        wr(8'hf2, 16'h0400);
        @(posedge i_sys_clk);
        #1 chk_bit(o_irq, 1'b1);
        wr(8'hf1, 16'h0400);
        @(posedge i_sys_clk);
        #1 chk_bit(o_irq, 1'b0);
        rd(8'hf1, 16'h0000);
        // A masked event sets status but keeps the line low until unmasked.
        wr(8'hf2, 16'h0000);
        smp(4'ha, 16'h006e);
        chk_bit(o_irq, 1'b0);
        rd(8'hf1, 16'h0400);
        wr(8'hf2, 16'h0400);
        @(posedge i_sys_clk);
        #1 chk_bit(o_irq, 1'b1);
        // Read-only places ignore writes and keep their values; unmapped places read back zero.
        wr({4'ha, ilc_pkg::F_MEAS}, 16'h1234);
        rd({4'ha, ilc_pkg::F_MEAS}, 16'h006e);
        wr(8'hf0, 16'h0000);
        rd(8'hf0, 16'h0402);
        rd(8'he0, 16'h0000);
        rd(8'hb0, 16'h0000);
        // A second reset in mid-run clears outputs and states.
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        @(posedge i_sys_clk);
        #1 chk_data({5'h00, o_report}, 16'h0000);
        chk_bit(o_irq, 1'b0);
        @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        rd({4'ha, ilc_pkg::F_STATE}, 16'h0000);
        smp(4'ha, 16'h0032);
        rd({4'ha, ilc_pkg::F_STATE}, 16'h0001);
        // A first sample above the high threshold lands in high directly.
        wr({4'h9, ilc_pkg::F_HTHR}, 16'h0064);
        smp(4'h9, 16'h00c8);
        rd({4'h9, ilc_pkg::F_STATE}, 16'h0002);
        wrap_up();
    end
endmodule
